/* File: shared/fps_map.svh */
// constants for the flash program and signature sequencer
`ifndef FPS_MAP_SVH
`define FPS_MAP_SVH
`define FPS_OFS_W0        4'h0
`define FPS_OFS_W3        4'hc
`define FPS_CLK_NS        25
`define FPS_TIMER_UNIT    512
`define FPS_TIMER_EXTRA   2
`define FPS_TR_W          10
`define FPS_DIV_W         16
`define FPS_ADDR_W        18
`define FPS_PAGE_LSB      9
`define FPS_SECT_LSB      13
`define FPS_NSECT         32
`define FPS_SIG_RESET     16'h0000
`define FPS_WIDE_RESET    128'h0
`define FPS_IRQ_BURN      1
`define FPS_IRQ_SIG       2
`endif

/* File: shared/fps_pkg.sv */
// types for the flash program and signature sequencer
package fps_pkg;
   typedef struct packed {
      logic load_request;
      logic program_request;
      logic protect_strobe_n;
      logic array_write_n;
      logic write_path_enable;
      logic chip_select;
      logic index_sector_select;
   } fps_trig_t;

   typedef struct packed {
      logic [127:0] data;
      logic [7:0]   upper;
      logic         ecc_error_flag;
      logic         ecc_check_high;
      logic         ecc_check_low;
   } fps_rdata_t;

   typedef enum logic [2:0] {
      FPS_IDLE  = 3'b000,
      FPS_BURN  = 3'b001,
      FPS_SREQ  = 3'b010,
      FPS_SWAIT = 3'b011,
      FPS_SNEXT = 3'b100
   } fps_state_t;
endpackage

/* File: design/fps_divider.sv */
// slow burn clock enable divider
`timescale 1ns/1ps
`default_nettype none
`include "fps_map.svh"
module fps_divider (
   input  wire logic                   clock_i,
   input  wire logic                   nrst_i,
   input  wire logic [`FPS_DIV_W-1:0]  div_i,
   output logic                        tick_o
);
   logic [`FPS_DIV_W-1:0] cnt;
   wire                   wrap = (cnt >= div_i - `FPS_DIV_W'(1));

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt    <= '0;
         tick_o <= 1'b0;
      end else if (div_i == '0) begin
         // zero divider stops the slow clock
         cnt    <= '0;
         tick_o <= 1'b0;
      end else begin
         cnt    <= wrap ? '0 : cnt + `FPS_DIV_W'(1);
         tick_o <= wrap;
      end
   end
endmodule
`default_nettype wire

/* File: design/fps_sequencer.sv */
// flash program and signature sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fps_map.svh"
module fps_sequencer (
   input  wire logic                    clock_i,
   input  wire logic                    nrst_i,
   input  wire logic                    dp_sel_i,
   input  wire logic                    dp_full_word_i,
   input  wire logic [`FPS_ADDR_W-1:0]  dp_addr_i,
   input  wire logic [31:0]             dp_wdata_i,
   input  wire logic                    latch_preset_bit_i,
   input  wire logic                    trig_we_i,
   input  wire fps_pkg::fps_trig_t      trig_i,
   input  wire logic                    timer_we_i,
   input  wire logic [`FPS_TR_W-1:0]    timer_count_field_i,
   input  wire logic                    timer_en_i,
   input  wire logic [`FPS_DIV_W-1:0]   slow_clock_divider_i,
   input  wire logic [`FPS_NSECT-1:0]   sector_protected_i,
   input  wire logic [`FPS_ADDR_W-1:0]  signature_start_addr_i,
   input  wire logic                    stop_we_i,
   input  wire logic [`FPS_ADDR_W-1:0]  signature_stop_addr_i,
   input  wire logic                    signature_go_bit_i,
   input  wire logic                    jtag_trig_i,
   input  wire logic                    array_ready_i,
   input  wire fps_pkg::fps_rdata_t     array_rdata_i,
   output logic                         dp_ready_o,
   output logic                         dp_error_o,
   output logic                         latch_preset_o,
   output logic                         latch_load_o,
   output logic [127:0]                 latch_data_o,
   output logic [`FPS_ADDR_W-1:0]       latch_addr_o,
   output logic                         burn_write_o,
   output logic                         burn_index_o,
   output logic [`FPS_ADDR_W-1:0]       burn_page_o,
   output logic [`FPS_TR_W-1:0]         timer_value_o,
   output logic                         slow_burn_clock_o,
   output logic                         array_read_o,
   output logic [`FPS_ADDR_W-1:0]       array_addr_o,
   output logic [2:0]                   irq_status_o,
   output logic                         busy_o,
   output logic [15:0]                  short_signature_reg_o,
   output logic [127:0]                 wide_signature_o
);
   fps_pkg::fps_state_t state;
   fps_pkg::fps_state_t next_state;
   logic [31:0]            word_q [4];
   logic                   auto_load;
   logic                   preset_q;
   logic                   beat_wait;
   logic [8:0]             prescale;
   logic                   rdy_s1;
   logic                   rdy_s2;
   logic                   rdy_low_seen;
   logic                   sig_jtag;
   logic [`FPS_ADDR_W-1:0] sig_addr;
   logic                   slow_tick;

   // trigger decoding, each pattern compared in one place
   function automatic logic trig_is(input fps_pkg::fps_trig_t t,
                                    input logic [5:0] pat);
      return {t.load_request, t.program_request, t.protect_strobe_n,
              t.array_write_n, t.write_path_enable, t.chip_select} == pat;
   endfunction

   wire trig_auto = trig_we_i && trig_is(trig_i, 6'h07);
   wire trig_man  = trig_we_i && trig_is(trig_i, 6'h27);
   wire trig_burn = trig_we_i && trig_is(trig_i, 6'h1b);
   wire beat_ok   = dp_sel_i && dp_full_word_i && !beat_wait;
   wire beat_bad  = dp_sel_i && !dp_full_word_i && !beat_wait;
   wire [1:0] word_idx = dp_addr_i[3:2];
   wire auto_hit  = beat_ok && auto_load &&
                    dp_addr_i[3:0] == `FPS_OFS_W3;
   wire [4:0] burn_sect = burn_page_o[`FPS_SECT_LSB+:5];
   wire sect_free = !sector_protected_i[burn_sect];
   wire timer_zero = timer_value_o == '0;
   wire pre_wrap = prescale == 9'(`FPS_TIMER_UNIT - 1);
   wire sig_last = sig_addr == signature_stop_addr_i;
   wire sig_go = stop_we_i && signature_go_bit_i;
   wire sig_start = (sig_go || jtag_trig_i) && state == fps_pkg::FPS_IDLE;
   wire [127:0] word_cat = {word_q[3], word_q[2], word_q[1], word_q[0]};
   // ready left high by the last read must drop before it counts
   wire rdy_step = state == fps_pkg::FPS_SWAIT && rdy_s2 && rdy_low_seen;
   wire [`FPS_ADDR_W-1:0] sig_addr_inc = sig_addr + `FPS_ADDR_W'(1);
   wire [15:0] next_sig = {
      short_signature_reg_o[0] ^ short_signature_reg_o[4] ^
      short_signature_reg_o[13] ^ short_signature_reg_o[15],
      short_signature_reg_o[15:12],
      array_rdata_i.ecc_check_low  ^ short_signature_reg_o[11],
      array_rdata_i.ecc_check_high ^ short_signature_reg_o[10],
      array_rdata_i.ecc_error_flag ^ short_signature_reg_o[9],
      array_rdata_i.upper ^ short_signature_reg_o[8:1]};
   // 128-bit signature, same shift-xor structure on corrected data
   wire [127:0] next_wide = {wide_signature_o[0] ^ wide_signature_o[2] ^
      wide_signature_o[27] ^ wide_signature_o[29],
      wide_signature_o[127:1]} ^ array_rdata_i.data;

   always_comb begin
      next_state = state;
      case (state)
         fps_pkg::FPS_IDLE: begin
            if (trig_burn && timer_en_i && slow_burn_clock_o)
               next_state = fps_pkg::FPS_BURN;
            else if (sig_start)
               next_state = fps_pkg::FPS_SREQ;
         end
         fps_pkg::FPS_BURN: begin
            if (timer_zero && pre_wrap)
               next_state = fps_pkg::FPS_IDLE;
         end
         fps_pkg::FPS_SREQ:  next_state = fps_pkg::FPS_SWAIT;
         fps_pkg::FPS_SWAIT: begin
            // ready only, read wait config is not consulted
            if (rdy_step)
               next_state = fps_pkg::FPS_SNEXT;
         end
         fps_pkg::FPS_SNEXT: begin
            next_state = sig_last ? fps_pkg::FPS_IDLE : fps_pkg::FPS_SREQ;
         end
         default: next_state = fps_pkg::FPS_IDLE;
      endcase
   end

   fps_divider u_div (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .div_i   (slow_clock_divider_i),
      .tick_o  (slow_tick)
   );

   // data port: wait state, word capture, page address
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         beat_wait  <= 1'b0;
         dp_ready_o <= 1'b0;
         dp_error_o <= 1'b0;
         for (int i = 0; i < 4; i++) word_q[i] <= '0;
         burn_page_o  <= '0;
         latch_addr_o <= '0;
      end else begin
         beat_wait  <= beat_ok;
         dp_ready_o <= beat_ok;
         dp_error_o <= beat_bad;
         if (beat_ok) begin
            word_q[word_idx] <= dp_wdata_i;
            burn_page_o  <= dp_addr_i;
            latch_addr_o <= dp_addr_i;
         end
      end
   end

   // latch loading and preset
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         auto_load      <= 1'b0;
         preset_q       <= 1'b0;
         latch_preset_o <= 1'b0;
         latch_load_o   <= 1'b0;
         latch_data_o   <= `FPS_WIDE_RESET;
      end else begin
         preset_q <= latch_preset_bit_i;
         // flash latches only; word_q stays as written
         latch_preset_o <= preset_q && !latch_preset_bit_i;
         if (trig_auto) auto_load <= 1'b1;
         else if (trig_we_i) auto_load <= 1'b0;
         latch_load_o <= auto_hit || trig_man;
         if (auto_hit)
            latch_data_o <= {dp_wdata_i, word_cat[95:0]};
         else if (trig_man)
            latch_data_o <= word_cat;
      end
   end

   // burn timer and signature engine
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state             <= fps_pkg::FPS_IDLE;
         prescale          <= '0;
         timer_value_o     <= '0;
         burn_write_o      <= 1'b0;
         burn_index_o      <= 1'b0;
         slow_burn_clock_o <= 1'b0;
         rdy_s1            <= 1'b0;
         rdy_s2            <= 1'b0;
         rdy_low_seen      <= 1'b0;
         array_read_o      <= 1'b0;
         array_addr_o      <= '0;
         sig_addr          <= '0;
         sig_jtag          <= 1'b0;
         irq_status_o      <= '0;
         busy_o            <= 1'b0;
         short_signature_reg_o <= `FPS_SIG_RESET;
         wide_signature_o  <= `FPS_WIDE_RESET;
      end else begin
         state             <= next_state;
         slow_burn_clock_o <= slow_tick || (slow_burn_clock_o &&
                              slow_clock_divider_i != '0);
         rdy_s1 <= array_ready_i;
         rdy_s2 <= rdy_s1;
         // a dip shorter than the synchroniser would stall here
         if (state == fps_pkg::FPS_SREQ)
            rdy_low_seen <= 1'b0;
         else if (state == fps_pkg::FPS_SWAIT && !rdy_s2)
            rdy_low_seen <= 1'b1;
         busy_o <= next_state != fps_pkg::FPS_IDLE;
         irq_status_o <= '0;
         if (timer_we_i && state != fps_pkg::FPS_BURN)
            timer_value_o <= timer_count_field_i;
         if (state == fps_pkg::FPS_IDLE &&
             next_state == fps_pkg::FPS_BURN) begin
            prescale     <= '0;
            burn_write_o <= sect_free;
            burn_index_o <= trig_i.index_sector_select;
         end
         if (state == fps_pkg::FPS_BURN) begin
            prescale <= pre_wrap ? '0 : prescale + 9'd1;
            if (pre_wrap && !timer_zero)
               timer_value_o <= timer_value_o - `FPS_TR_W'(1);
            if (next_state == fps_pkg::FPS_IDLE) begin
               burn_write_o <= 1'b0;
               irq_status_o[`FPS_IRQ_BURN] <= 1'b1;
            end
         end
         if (sig_start) begin
            sig_addr  <= signature_start_addr_i;
            sig_jtag  <= jtag_trig_i && !sig_go;
            short_signature_reg_o <= `FPS_SIG_RESET;
            wide_signature_o <= `FPS_WIDE_RESET;
         end
         array_read_o <= next_state == fps_pkg::FPS_SREQ;
         if (next_state == fps_pkg::FPS_SREQ)
            array_addr_o <= (state == fps_pkg::FPS_SNEXT) ?
                            sig_addr_inc : (sig_start ?
                            signature_start_addr_i : sig_addr);
         if (rdy_step) begin
            short_signature_reg_o <= next_sig;
            wide_signature_o <= next_wide;
         end
         if (state == fps_pkg::FPS_SNEXT) begin
            sig_addr <= sig_addr_inc;
            if (sig_last && !sig_jtag)
               irq_status_o[`FPS_IRQ_SIG] <= 1'b1;
         end
      end
   end

   a_burn_timeout: assert property (@(posedge clock_i) disable iff (!nrst_i)
      state == fps_pkg::FPS_BURN && next_state == fps_pkg::FPS_IDLE
      |=> !burn_write_o && irq_status_o[`FPS_IRQ_BURN])
      else $error("burn end not signalled");
   a_timer_down: assert property (@(posedge clock_i) disable iff (!nrst_i)
      state == fps_pkg::FPS_BURN && pre_wrap && !timer_zero
      |=> timer_value_o == $past(timer_value_o) - `FPS_TR_W'(1))
      else $error("timer did not decrement");
   a_auto_load: assert property (@(posedge clock_i) disable iff (!nrst_i)
      auto_hit |=> latch_load_o && latch_data_o[127:96] ==
      $past(dp_wdata_i))
      else $error("auto load missed");
   a_beat_two: assert property (@(posedge clock_i) disable iff (!nrst_i)
      beat_ok |=> dp_ready_o && beat_wait)
      else $error("beat not two cycles");
   a_no_partial: assert property (@(posedge clock_i) disable iff (!nrst_i)
      beat_bad |=> dp_error_o && !dp_ready_o)
      else $error("partial write accepted");
   a_preset_edge: assert property (@(posedge clock_i) disable iff (!nrst_i)
      latch_preset_o |-> $past(preset_q) && !$past(latch_preset_bit_i))
      else $error("preset without set then clear");
   a_prot_burn: assert property (@(posedge clock_i) disable iff (!nrst_i)
      state == fps_pkg::FPS_IDLE && next_state == fps_pkg::FPS_BURN &&
      !sect_free |=> !burn_write_o)
      else $error("protected page burned");
   sequence s_ready_seen;
      rdy_step;
   endsequence
   a_sig_step: assert property (@(posedge clock_i) disable iff (!nrst_i)
      s_ready_seen |=> state == fps_pkg::FPS_SNEXT ##1
      (state == fps_pkg::FPS_SREQ || state == fps_pkg::FPS_IDLE))
      else $error("signature step wrong");
   a_manual_ld: assert property (@(posedge clock_i) disable iff (!nrst_i)
      trig_man && !auto_hit |=> latch_data_o == $past(word_cat))
      else $error("manual load data wrong");
   a_sig_next: assert property (@(posedge clock_i) disable iff (!nrst_i)
      state == fps_pkg::FPS_SNEXT && !sig_last |=> array_read_o &&
      array_addr_o == $past(sig_addr) + `FPS_ADDR_W'(1))
      else $error("signature address not stepped");
endmodule
`default_nettype wire

/* File: sim/fps_array_model.sv */
// flash array stand-in answering signature reads
`timescale 1ns/1ps
`default_nettype none
`include "fps_map.svh"
module fps_array_model #(
   parameter int DELAY = 3
) (
   input  wire logic                   clock_i,
   input  wire logic                   read_i,
   input  wire logic [`FPS_ADDR_W-1:0] addr_i,
   output logic                        ready_o,
   output fps_pkg::fps_rdata_t         rdata_o
);
   int                         cnt = 0;
   logic [`FPS_ADDR_W-1:0]     a = '0;
   fps_pkg::fps_rdata_t        q;
   // data is a pure function of the address so the bench can predict it
   always_comb begin
      q.data = {8{a[15:0]}};
      q.upper = a[7:0] ^ 8'h5a;
      q.ecc_error_flag = a[0];
      q.ecc_check_high = a[1];
      q.ecc_check_low = a[2];
   end
   // not ready: inverted data, so stale values never pass as valid
   assign rdata_o = ready_o ? q : ~q;
   initial ready_o = 1'b1;
   // ready is slow and unrelated to any wait setting
   always @(posedge clock_i) begin
      if (read_i) begin
         a <= addr_i;
         cnt <= DELAY;
         ready_o <= 1'b0;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else begin
         ready_o <= 1'b1;
      end
   end
endmodule
`default_nettype wire

/* File: sim/fps_sequencer_tb.sv */
// self-checking bench for the flash program and signature sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fps_map.svh"
module fps_sequencer_tb;
   logic clock_i = 0, nrst_i = 0, dp_sel_i = 0, dp_full_word_i = 0;
   logic [17:0] dp_addr_i = '0, sa = 18'h10, so = '0;
   logic [31:0] dp_wdata_i = '0;
   logic pre_i = 0, trig_we_i = 0, timer_we_i = 0, timer_en_i = 0;
   fps_pkg::fps_trig_t trig_i = '0;
   logic [9:0] tr = '0, tv;
   logic [15:0] div = 16'h0002, ssig, exp_sig;
   logic [31:0] prot = '0;
   logic stop_we_i = 0, go = 0, jtag_i = 0, ry, rd, rdy, err, load;
   logic pres, bw, bi, sbc, busy, s_rdy, s_err, s_load, s_pre;
   logic [127:0] ld, ldata, wsig, exp_w;
   logic [17:0] la, bp, aa;
   logic [2:0] irq, s_irq;
   fps_pkg::fps_rdata_t rdat;
   int err_total = 0, n_checks = 0, n;
   typedef struct {logic [17:0] a; logic f; logic [31:0] d;
      logic r; logic e; logic l;} fps_row_t;
   fps_row_t rows[5] = '{
      '{18'h00400, 1, 32'h11111111, 1, 0, 0},
      '{18'h00404, 1, 32'hffffff5a, 1, 0, 0},
      '{18'h00408, 1, 32'h33333333, 1, 0, 0},
      '{18'h0040c, 1, 32'h44444444, 1, 0, 1},
      '{18'h00404, 0, 32'h0000abcd, 0, 1, 0}};

   fps_sequencer uut (.clock_i(clock_i), .nrst_i(nrst_i),
      .dp_sel_i(dp_sel_i), .dp_full_word_i(dp_full_word_i),
      .dp_addr_i(dp_addr_i), .dp_wdata_i(dp_wdata_i),
      .latch_preset_bit_i(pre_i), .trig_we_i(trig_we_i), .trig_i(trig_i),
      .timer_we_i(timer_we_i), .timer_count_field_i(tr),
      .timer_en_i(timer_en_i), .slow_clock_divider_i(div),
      .sector_protected_i(prot), .signature_start_addr_i(sa),
      .stop_we_i(stop_we_i), .signature_stop_addr_i(so),
      .signature_go_bit_i(go), .jtag_trig_i(jtag_i),
      .array_ready_i(ry), .array_rdata_i(rdat), .dp_ready_o(rdy),
      .dp_error_o(err), .latch_preset_o(pres), .latch_load_o(load),
      .latch_data_o(ld), .latch_addr_o(la), .burn_write_o(bw),
      .burn_index_o(bi), .burn_page_o(bp), .timer_value_o(tv),
      .slow_burn_clock_o(sbc), .array_read_o(rd), .array_addr_o(aa),
      .irq_status_o(irq), .busy_o(busy), .short_signature_reg_o(ssig),
      .wide_signature_o(wsig));
   fps_array_model mdl (.clock_i(clock_i), .read_i(rd), .addr_i(aa),
      .ready_o(ry), .rdata_o(rdat));

   always #12.5 clock_i = ~clock_i;

   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [127:0] e, logic [127:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   // pulses stand one cycle, so every cycle is sampled and accumulated
   task automatic cyc(int k);
      repeat (k) begin
         @(posedge clock_i);
         #1;
         s_rdy |= rdy;
         s_err |= err;
         s_load |= load;
         s_pre |= pres;
         s_irq |= irq;
         if (load) ldata = ld;
      end
   endtask
   task automatic clr;
      {s_rdy, s_err, s_load, s_pre, s_irq} = '0;
   endtask
   task automatic beat(logic [17:0] a, logic f, logic [31:0] d);
      {dp_sel_i, dp_addr_i, dp_full_word_i, dp_wdata_i} = {1'b1, a, f, d};
      clr;
      cyc(1);
      dp_sel_i = 0;
      cyc(2);
   endtask
   task automatic trig(logic [6:0] v);
      {trig_we_i, trig_i} = {1'b1, v};
      cyc(1);
      trig_we_i = 0;
   endtask
   task automatic arm(logic [9:0] t);
      {timer_we_i, tr, timer_en_i} = {1'b1, t, 1'b1};
      cyc(1);
      timer_we_i = 0;
   endtask
   task automatic burn_wait;
      n = 0;
      clr;
      while (!s_irq[1] && n < 1100) begin
         cyc(1);
         n += bw;
      end
   endtask
   function automatic logic [15:0] step(logic [15:0] s, logic [17:0] a);
      logic [15:0] x;
      logic [7:0] u;
      u = a[7:0] ^ 8'h5a;
      for (int i = 0; i < 8; i++) x[i] = u[i] ^ s[i+1];
      x[10:8] = a[2:0] ^ s[11:9];
      x[14:11] = s[15:12];
      x[15] = s[0] ^ s[4] ^ s[13] ^ s[15];
      return x;
   endfunction
   function automatic logic [127:0] wstep(logic [127:0] w, logic [17:0] a);
      return {w[0] ^ w[2] ^ w[27] ^ w[29], w[127:1]} ^ {8{a[15:0]}};
   endfunction

   initial begin
      #500000;
      err_total++;
      stop_test;
   end
   initial begin
      repeat (16) @(posedge clock_i);
      #1;
      nrst_i = 1;
      cyc(1);
      chk("idle", 0, {irq, busy, bw, load});
      trig(7'b0001110);
      foreach (rows[i]) begin
         beat(rows[i].a, rows[i].f, rows[i].d);
         chk("ans", {rows[i].r, rows[i].e, rows[i].l}, {s_rdy, s_err, s_load});
      end
      chk("wide", 128'h4444444433333333ffffff5a11111111, ldata);
      clr;
      trig(7'b1001110);
      cyc(3);
      chk("man", {1'b1, rows[3].d, rows[2].d}, {s_load, ldata[127:64]});
      pre_i = 1;
      cyc(2);
      pre_i = 0;
      clr;
      cyc(3);
      chk("pre", 2'b10, {s_pre, s_load});
      trig(7'b1001110);
      cyc(2);
      chk("keep", rows[3].d, ldata[127:96]);
      beat(18'h02008, 1, 32'h0);
      arm(10'h001);
      trig(7'b0110110);
      cyc(1);
      chk("page", {1'b1, 18'h02008}, {bw, bp});
      burn_wait;
      chk("burn", {32'd1022, 3'b010, 10'h0}, {n, s_irq, tv});
      prot = 32'h2;
      arm(10'h000);
      trig(7'b0110110);
      clr;
      cyc(4);
      chk("prot", 0, bw);
      burn_wait;
      prot = '0;
      arm(10'h000);
      trig(7'b0110111);
      cyc(1);
      chk("idx", 2'b11, {bw, bi});
      burn_wait;
      div = '0;
      cyc(4);
      arm(10'h000);
      trig(7'b0110110);
      cyc(3);
      chk("stop", 0, {sbc, bw});
      div = 16'h0002;
      exp_sig = `FPS_SIG_RESET;
      exp_w = `FPS_WIDE_RESET;
      for (int a = 16; a < 20; a++) begin
         exp_sig = step(exp_sig, 18'(a));
         exp_w = wstep(exp_w, 18'(a));
      end
      {so, go, stop_we_i} = {18'h13, 2'b11};
      cyc(1);
      {go, stop_we_i} = 0;
      clr;
      for (int k = 0; k < 300 && !s_irq[2]; k++) cyc(1);
      chk("sig", {1'b1, exp_sig}, {s_irq[2], ssig});
      chk("wsig", exp_w, wsig);
      jtag_i = 1;
      cyc(1);
      jtag_i = 0;
      clr;
      for (int k = 0; k < 300 && busy !== 0; k++) cyc(1);
      chk("jtag", {2'b0, exp_sig}, {s_irq[2], busy, ssig});
      chk("jwsig", exp_w, wsig);
      arm(10'h001);
      trig(7'b0110110);
      cyc(5);
      chk("burning", 1'b1, bw);
      nrst_i = 0;
      cyc(1);
      chk("rst", 0, {bw, busy, tv, irq, wsig});
      nrst_i = 1;
      stop_test;
   end
endmodule
`default_nettype wire
